/* sim/lcdcs_checker.sv */
// Concurrent checks on the link between the host end and the driver end
`timescale 1ns/1ns
module lcdcs_checker #(
  parameter int BP_NUM = 4
) (
  // Link clock and driver reset
  input wire logic              link_clk,
  input wire logic              por_n,
  // Link lines
  input wire logic              scl,
  input wire logic              sync_n,
  input wire logic              dev_sda_oe,
  input wire logic              dev_sync_oe,
  input wire logic              dev_clk_o,
  input wire logic              dev_clk_oe,
  // Driver slot and clock strap
  input wire logic [BP_NUM-1:0] backplane_active,
  input wire logic              clock_source_select_pin
);
  default clocking @(posedge link_clk); endclocking
  default disable iff (!por_n);

  logic [4:0] low_cnt_reg;
  logic [4:0] low_cnt_next;
  logic [3:0] rise_cnt_reg;
  logic [3:0] rise_cnt_next;
  logic       scl_reg;

  // Length of own sync pull, and wake clock rises seen so far
  always_comb begin
    low_cnt_next  = dev_sync_oe ? low_cnt_reg + 5'h01 : 5'h00;
    rise_cnt_next = (scl && !scl_reg && rise_cnt_reg != 4'h9) ? rise_cnt_reg + 4'h1 : rise_cnt_reg;
  end

  // Helper registers
  always_ff @(posedge link_clk or negedge por_n) begin
    if (!por_n) begin
      low_cnt_reg  <= 5'h00;
      rise_cnt_reg <= 4'h0;
      scl_reg      <= 1'b1;
    end else begin
      low_cnt_reg  <= low_cnt_next;
      rise_cnt_reg <= rise_cnt_next;
      scl_reg      <= scl;
    end
  end

  a_sync_in_last: assert property (dev_sync_oe && $past(dev_sync_oe) |-> backplane_active[BP_NUM-1])
    else $error("sync pulled outside the last slot");
  a_sync_at_onset: assert property ($rose(backplane_active[BP_NUM-1]) && sync_n |-> ##[0:1] dev_sync_oe)
    else $error("sync not pulled at last slot onset");
  a_sync_low_width: assert property ($fell(dev_sync_oe) |-> low_cnt_reg == 5'h15)
    else $error("sync pull length wrong");
  a_slot_one_hot: assert property ($onehot(backplane_active))
    else $error("slot not one-hot");
  a_slot_wraps: assert property ($rose(backplane_active[0]) |-> $past(backplane_active[BP_NUM-1]))
    else $error("slot zero entered out of order");
  a_realign_bound: assert property ($fell(sync_n) |-> ##[0:4] backplane_active[BP_NUM-1])
    else $error("no realign after sync fall");
  a_ack_after_wake: assert property (dev_sda_oe |-> rise_cnt_reg == 4'h9)
    else $error("ack before nine wake clocks");
  a_ack_scl_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("ack pull began with clock high");
  a_clk_half_duty: assert property (dev_clk_oe && $past(dev_clk_oe) && $past(por_n) |-> dev_clk_o != $past(dev_clk_o))
    else $error("clock out not toggling each cycle");
  a_ext_clk_off: assert property (clock_source_select_pin [*4] |-> !dev_clk_oe)
    else $error("clock pin driven with external select");
  a_int_clk_on: assert property (!clock_source_select_pin [*4] |-> dev_clk_oe)
    else $error("clock pin not driven with internal select");
endmodule : lcdcs_checker

/* sim/tb_lcd_driver_cascade_sync.sv */
// Self-checking bench: host end and driver end joined over the link
`timescale 1ns/1ns
`define LCDCS_CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_lcd_driver_cascade_sync;
  logic        pclk, presetn, por_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic        pready, pslverr, csel, tgt_bit, awake, selected;
  logic [2:0]  strap;
  logic [3:0]  dev_index, idx, bp;
  logic [32:0] exp_q[$], msk_q[$];
  int          n_mismatch, n_checks, cyc;

  lcdcs_link_if link0();
  lcdcs_host_end u_lcdcs_host_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link0), .clock_source_select_pin(csel));
  lcdcs_driver_end #(.BP_NUM(4), .SLOT_LEN(32)) u_lcdcs_driver_end (.link(link0), .por_n(por_n),
    .target_address_select_bit(tgt_bit), .subaddress_strap_0(strap[0]), .subaddress_strap_1(strap[1]),
    .subaddress_strap_2(strap[2]), .clock_source_select_pin(csel), .backplane_active(bp),
    .device_index(dev_index), .awake(awake), .selected(selected));
  lcdcs_checker #(.BP_NUM(4)) u_lcdcs_checker (.link_clk(link0.link_clk), .por_n(por_n), .scl(link0.scl),
    .sync_n(link0.sync_n), .dev_sda_oe(link0.dev_sda_oe), .dev_sync_oe(link0.dev_sync_oe),
    .dev_clk_o(link0.dev_clk_o), .dev_clk_oe(link0.dev_clk_oe), .backplane_active(bp),
    .clock_source_select_pin(csel));

  // Bus clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // Each read answer is compared with the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      `LCDCS_CHK({pslverr, prdata} & msk_q[0], exp_q[0] & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  // One bus transfer, held until ready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read with an expected value under a mask
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Start a serial transfer and wait until busy falls
  task automatic xfer(input logic s, input logic [2:0] sub);
    apb(1'b1, 12'h000, {23'h0, 1'b1, 3'h0, sub, s, 1'b1});
    for (int i = 0; i < 2000; i++) begin
      rd(12'h004, 33'h010, 33'h100000010); // Woken stays set
      if (rd_data[0] === 1'b0) break;
    end
  endtask : xfer

  // Main sequence
  initial begin
    presetn = 1'b0;
    por_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tgt_bit = 1'b0;
    strap = 3'h0;
    link0.ext_sync_oe = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    void'($urandom(28095));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    por_n <= 1'b1;
    @(negedge pclk);
    `LCDCS_CHK(bp, 4'h1) // Slot zero
    `LCDCS_CHK(csel, 1'b1) // External select
    rd(12'h000, 33'h100, 33'h1FFFFFFFF); // Control reset value
    for (int i = 0; i < 400 && rd_data[4] !== 1'b1; i++) rd(12'h004, 33'h0, 33'h0);
    rd(12'h004, 33'h10, 33'h1F); // Woken and idle
    repeat (8) @(negedge pclk);
    `LCDCS_CHK(awake, 1'b1) // Driver awake
    // Unmapped place: refused, and no side effect
    rd(12'h008, {1'b1, 32'h0}, 33'h1FFFFFFFF);
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    rd(12'h000, 33'h100, 33'h1FFFFFFFF);
    // Every strap setting decodes to its device number
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk);
      {tgt_bit, strap} <= i[3:0];
      repeat (8) @(negedge pclk);
      `LCDCS_CHK(dev_index, i[3:0]) // Device number
    end
    idx = 4'($urandom);
    @(posedge pclk);
    {tgt_bit, strap} <= idx;
    repeat (8) @(posedge pclk);
    xfer(~idx[3], idx[2:0]);
    rd(12'h004, 33'h18, 33'h1B); // First access resent
    xfer(~idx[3], idx[2:0]);
    rd(12'h004, 33'h14, 33'h1F); // Later access not resent
    xfer(idx[3], idx[2:0] ^ 3'(1 + $urandom % 7));
    @(negedge pclk);
    `LCDCS_CHK(selected, 1'b0) // Wrong position ignored
    xfer(idx[3], idx[2:0]);
    rd(12'h004, 33'h12, 33'h1F); // Both bytes acknowledged
    @(negedge pclk);
    `LCDCS_CHK(selected, 1'b1) // Addressed driver
    // Internal clock select makes the driver drive its clock pin
    apb(1'b1, 12'h000, 32'h0);
    repeat (40) @(negedge pclk);
    `LCDCS_CHK({csel, link0.dev_clk_oe}, 2'b01) // Driver supplies clock
    apb(1'b1, 12'h000, 32'h100);
    repeat (12) @(negedge pclk);
    `LCDCS_CHK({csel, link0.dev_clk_oe}, 2'b10) // Driver takes clock
    // Another cascade member pulls sync at random moments
    repeat (3) begin
      repeat (50 + $urandom % 200) @(posedge pclk);
      link0.ext_sync_oe <= 1'b1;
      repeat (8) @(negedge pclk);
      `LCDCS_CHK(bp, 4'h8) // Moved to last slot
      repeat (18) @(posedge pclk);
      link0.ext_sync_oe <= 1'b0;
    end
    repeat (100) @(posedge pclk);
    report_and_stop();
  end
endmodule : tb_lcd_driver_cascade_sync

/* verilog/lcdcs_defines.svh */
// Shared constants for the cascade addressing and frame sync block
// What this block does
// - Host toggles serial clock nine times after power-up
// - Host resends first command when its address byte is not acknowledged
// - Sixteen drivers told apart by straps plus target bit
// - Target bit picks cluster, straps pick position
// - All drivers start aligned after reset
// - Frame sync pin open-drain, pulled up internally
// - Drive sync at last slot onset, else sample
// - Realign to first driver asserting sync
// - One clock source shared by whole cascade
// - Select pin high: use external clock pin
// - Driven clock output has half duty factor
`ifndef LCDCS_DEFINES_SVH
`define LCDCS_DEFINES_SVH

// Serial address byte: fixed part, then target bit, then direction
`define LCDCS_ADDR_BASE     6'h1C
`define LCDCS_WAKE_PULSES   4'h9

// Register offsets on the APB side
`define LCDCS_CTRL_OFS      12'h000
`define LCDCS_STAT_OFS      12'h004

// Control register fields
`define LCDCS_CTRL_GO       0
`define LCDCS_CTRL_TGT      1
`define LCDCS_CTRL_SUB_LSB  2
`define LCDCS_CTRL_EXTCLK   8

// Status register fields
`define LCDCS_STAT_BUSY     0
`define LCDCS_STAT_ACK      1
`define LCDCS_STAT_NACK     2
`define LCDCS_STAT_RETRY    3
`define LCDCS_STAT_WOKEN    4

// Timing
`define LCDCS_PCLK_NS       40
`define LCDCS_LINK_NS       48
`define LCDCS_SCL_QTR_NS    640
`define LCDCS_SCL_QTR_CYC   ((`LCDCS_SCL_QTR_NS + `LCDCS_PCLK_NS - 1) / `LCDCS_PCLK_NS)
`define LCDCS_SYNC_LOW_NS   1000
`define LCDCS_SYNC_LOW_CYC  ((`LCDCS_SYNC_LOW_NS + `LCDCS_LINK_NS - 1) / `LCDCS_LINK_NS)
`define LCDCS_SYNC_LAG      3

`endif

/* verilog/lcdcs_driver_end.sv */
// Display driver end: address decode, frame slots, frame sync, clock pin
`include "lcdcs_defines.svh"
`timescale 1ns/1ns
module lcdcs_driver_end
  import lcdcs_pkg::*;
#(
  parameter int BP_NUM   = 4,
  parameter int SLOT_LEN = 64
) (
  // Link pins
  lcdcs_link_if.dev             link,
  // Power-on reset
  input  wire logic             por_n,
  // Straps
  input  wire logic             target_address_select_bit,
  input  wire logic             subaddress_strap_0,
  input  wire logic             subaddress_strap_1,
  input  wire logic             subaddress_strap_2,
  input  wire logic             clock_source_select_pin,
  // Status toward the display core
  output logic [BP_NUM-1:0]     backplane_active,
  output logic [3:0]            device_index,
  output logic                  awake,
  output logic                  selected
);
  localparam int SW = $clog2(BP_NUM);
  localparam int TW = $clog2(SLOT_LEN);
  localparam logic [SW-1:0] LAST_SLOT = SW'(BP_NUM - 1);
  localparam logic [TW-1:0] LAG_TICK  = TW'(`LCDCS_SYNC_LAG);
  localparam logic [4:0]    SYNC_LOW  = 5'(`LCDCS_SYNC_LOW_CYC);

  logic       clk;
  logic [7:0] pins_s;
  logic       scl_s, sda_s, sync_s, sel_s, tgt_s;
  logic [2:0] sub_s;

  assign clk = link.link_clk;

  // All pins pass two flops on the link clock; the pulled-up lines and the clock select
  // pass inverted, so the flops leave reset at the idle high level and no false edge follows
  lcdcs_sync2 #(.WIDTH(8)) u_sync (
    .clk   (clk),
    .rst_n (por_n),
    .d     ({~link.scl, ~link.sda, ~link.sync_n, ~clock_source_select_pin, target_address_select_bit,
             subaddress_strap_2, subaddress_strap_1, subaddress_strap_0}),
    .q     (pins_s)
  );
  assign {scl_s, sda_s, sync_s, sel_s, tgt_s, sub_s} = pins_s ^ 8'hF0;

  // Bus decode state
  logic       scl_d_reg, sda_d_reg, sync_d_reg;
  logic [3:0] wake_reg, wake_next;
  logic       awake_reg, awake_next;
  logic       busy_reg, busy_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic       in_ack_reg, in_ack_next;
  logic       ack_reg, ack_next;
  logic       byte1_reg, byte1_next;
  logic       addr_reg, addr_next;
  logic       sel_reg, sel_next;
  logic       scl_rise, scl_fall, start_c, stop_c, match;

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // First byte matches on the fixed part plus the target bit
  assign match    = byte1_reg ? addr_reg : (sh_reg[7:1] == {`LCDCS_ADDR_BASE, tgt_s});

  // Next values of the bus decoder
  always_comb begin
    wake_next   = wake_reg;
    awake_next  = awake_reg;
    busy_next   = busy_reg;
    sh_next     = sh_reg;
    cnt_next    = cnt_reg;
    in_ack_next = in_ack_reg;
    ack_next    = ack_reg;
    byte1_next  = byte1_reg;
    addr_next   = addr_reg;
    sel_next    = sel_reg;
    // Nine clock pulses bring the interface out of its power-up state
    if (!awake_reg && scl_rise) begin
      wake_next = wake_reg + 4'h1;
      if (wake_reg == `LCDCS_WAKE_PULSES - 4'h1) begin
        awake_next = 1'b1;
      end
    end
    if (awake_reg) begin
      if (start_c) begin
        busy_next   = 1'b1;
        cnt_next    = 4'h0;
        in_ack_next = 1'b0;
        ack_next    = 1'b0;
        byte1_next  = 1'b0;
        addr_next   = 1'b0;
      end else if (stop_c) begin
        busy_next = 1'b0;
        ack_next  = 1'b0;
      end else if (busy_reg && scl_rise && cnt_reg != 4'h8) begin
        sh_next  = {sh_reg[6:0], sda_s};
        cnt_next = cnt_reg + 4'h1;
      end else if (busy_reg && scl_fall && cnt_reg == 4'h8) begin
        if (!in_ack_reg) begin
          in_ack_next = 1'b1;
          ack_next    = match;
        end else begin
          in_ack_next = 1'b0;
          ack_next    = 1'b0;
          cnt_next    = 4'h0;
          if (!byte1_reg) begin
            addr_next  = match;
            byte1_next = 1'b1;
            busy_next  = match;
          end else begin
            // Position within the cluster comes from the straps
            sel_next  = addr_reg && (sh_reg[2:0] == sub_s);
            busy_next = 1'b0;
          end
        end
      end
    end
  end

  // Bus decoder registers
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      scl_d_reg  <= 1'b1;
      sda_d_reg  <= 1'b1;
      wake_reg   <= 4'h0;
      awake_reg  <= 1'b0;
      busy_reg   <= 1'b0;
      sh_reg     <= 8'h00;
      cnt_reg    <= 4'h0;
      in_ack_reg <= 1'b0;
      ack_reg    <= 1'b0;
      byte1_reg  <= 1'b0;
      addr_reg   <= 1'b0;
      sel_reg    <= 1'b0;
    end else begin
      scl_d_reg  <= scl_s;
      sda_d_reg  <= sda_s;
      wake_reg   <= wake_next;
      awake_reg  <= awake_next;
      busy_reg   <= busy_next;
      sh_reg     <= sh_next;
      cnt_reg    <= cnt_next;
      in_ack_reg <= in_ack_next;
      ack_reg    <= ack_next;
      byte1_reg  <= byte1_next;
      addr_reg   <= addr_next;
      sel_reg    <= sel_next;
    end
  end

  // Frame slot state
  logic [SW-1:0] slot_reg, slot_next;
  logic [TW-1:0] tick_reg, tick_next;
  logic [4:0]    drv_reg, drv_next;
  logic          clk_out_reg;
  logic          sync_fall;

  assign sync_fall = sync_d_reg & ~sync_s;

  // Slot sequencing, sync drive and realignment
  always_comb begin
    slot_next = slot_reg;
    tick_next = tick_reg + TW'(1);
    drv_next  = (drv_reg != 5'h0) ? drv_reg - 5'h1 : 5'h0;
    if (tick_reg == TW'(SLOT_LEN - 1)) begin
      tick_next = '0;
      slot_next = (slot_reg == LAST_SLOT) ? '0 : slot_reg + SW'(1);
      if (slot_reg == LAST_SLOT - SW'(1)) begin
        drv_next = SYNC_LOW;
      end
    end
    // Any assertion seen jumps to the last slot, own assertions land in place
    if (sync_fall) begin
      slot_next = LAST_SLOT;
      tick_next = LAG_TICK;
    end
  end

  // Frame registers; every driver leaves reset in slot zero
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      slot_reg    <= '0;
      tick_reg    <= '0;
      drv_reg     <= 5'h0;
      sync_d_reg  <= 1'b1;
      clk_out_reg <= 1'b0;
    end else begin
      slot_reg    <= slot_next;
      tick_reg    <= tick_next;
      drv_reg     <= drv_next;
      sync_d_reg  <= sync_s;
      clk_out_reg <= ~clk_out_reg;
    end
  end

  // One-hot backplane slot indication
  genvar g;
  generate
    for (g = 0; g < BP_NUM; g++) begin : g_bp
      assign backplane_active[g] = (slot_reg == SW'(g));
    end
  endgenerate

  // Pin drivers: sync and data only ever pull low
  assign link.dev_sync_oe = (drv_reg != 5'h0);
  assign link.dev_sda_oe  = ack_reg;
  // Clock pin driven only when this driver is the clock source
  assign link.dev_clk_o   = clk_out_reg;
  assign link.dev_clk_oe  = ~sel_s;

  // User-side status
  assign device_index = {tgt_s, sub_s};
  assign awake        = awake_reg;
  assign selected     = sel_reg;
endmodule : lcdcs_driver_end

/* verilog/lcdcs_host_end.sv */
// Bus host end: APB registers, link clock divider, serial sequencer
`include "lcdcs_defines.svh"
`timescale 1ns/1ns
module lcdcs_host_end
  import lcdcs_pkg::*;
#(
  parameter int LINK_HALF = 1
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link pins
  lcdcs_link_if.host       link,
  // Strap output toward all drivers
  output logic             clock_source_select_pin
);
  localparam logic [7:0] QTR = 8'(`LCDCS_SCL_QTR_CYC);
  localparam logic [7:0] HALF = 8'(LINK_HALF);

  logic sda_s;
  lcdcs_sync2 #(.WIDTH(1)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (link.sda),
    .q     (sda_s)
  );

  // Link clock divider, shared by every cascade member
  logic [7:0] div_reg;
  logic       lclk_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= 8'h00;
      lclk_reg <= 1'b0;
    end else if (div_reg == HALF - 8'h1) begin
      div_reg  <= 8'h00;
      lclk_reg <= ~lclk_reg;
    end else begin
      div_reg  <= div_reg + 8'h01;
    end
  end
  assign link.link_clk = lclk_reg;

  // Register access
  logic       wr_ctrl, go_req;
  logic       tgt_reg, ext_reg, ack_ok_reg, nack_reg, retry_reg, woken_reg;
  logic [2:0] sub_reg;
  lcdcs_host_st_t st_reg, st_next;
  assign wr_ctrl = psel & penable & pwrite & (paddr == `LCDCS_CTRL_OFS);
  assign go_req  = wr_ctrl & pwdata[`LCDCS_CTRL_GO] & (st_reg == LCDCS_H_IDLE);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr != `LCDCS_CTRL_OFS) & (paddr != `LCDCS_STAT_OFS);

  // Read data mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == `LCDCS_CTRL_OFS) begin
      prdata[`LCDCS_CTRL_TGT]                      = tgt_reg;
      prdata[`LCDCS_CTRL_SUB_LSB+2:`LCDCS_CTRL_SUB_LSB] = sub_reg;
      prdata[`LCDCS_CTRL_EXTCLK]                   = ext_reg;
    end else if (paddr == `LCDCS_STAT_OFS) begin
      prdata[`LCDCS_STAT_BUSY]  = (st_reg != LCDCS_H_IDLE);
      prdata[`LCDCS_STAT_ACK]   = ack_ok_reg;
      prdata[`LCDCS_STAT_NACK]  = nack_reg;
      prdata[`LCDCS_STAT_RETRY] = retry_reg;
      prdata[`LCDCS_STAT_WOKEN] = woken_reg;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_reg <= 1'b0;
      sub_reg <= 3'h0;
      ext_reg <= 1'b1;
    end else if (wr_ctrl) begin
      tgt_reg <= pwdata[`LCDCS_CTRL_TGT];
      sub_reg <= pwdata[`LCDCS_CTRL_SUB_LSB+2:`LCDCS_CTRL_SUB_LSB];
      ext_reg <= pwdata[`LCDCS_CTRL_EXTCLK];
    end
  end
  assign clock_source_select_pin = ext_reg;

  // Sequencer state
  logic [7:0] q_reg, q_next;
  logic [1:0] ph_reg, ph_next;
  logic [3:0] n_reg, n_next;
  logic [7:0] sh_reg, sh_next;
  logic       b1_reg, b1_next;
  logic       first_reg, first_next;
  logic       scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic       ack_ok_next, nack_next, retry_next, woken_next;
  logic       tick, last;
  assign tick = (q_reg == 8'h00);
  assign last = tick & (ph_reg == 2'h3);

  // Next values: one serial bit is four quarter ticks
  always_comb begin
    st_next = st_reg;
    q_next = tick ? QTR - 8'h1 : q_reg - 8'h1;
    ph_next = tick ? ph_reg + 2'h1 : ph_reg;
    n_next = n_reg;
    sh_next = sh_reg;
    b1_next = b1_reg;
    first_next = first_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    ack_ok_next = ack_ok_reg;
    nack_next = nack_reg;
    retry_next = retry_reg;
    woken_next = woken_reg;
    unique case (st_reg)
      LCDCS_H_WAKE: begin
        if (tick) begin
          scl_oe_next = ~ph_reg[1] ? 1'b1 : 1'b0;
        end
        if (last) begin
          n_next = n_reg + 4'h1;
          if (n_reg == `LCDCS_WAKE_PULSES - 4'h1) begin
            st_next    = LCDCS_H_IDLE;
            woken_next = 1'b1;
          end
        end
      end
      LCDCS_H_IDLE: begin
        ph_next = 2'h0;
        if (go_req) begin
          st_next     = LCDCS_H_START;
          q_next      = QTR - 8'h1;
          ack_ok_next = 1'b0;
          nack_next   = 1'b0;
          retry_next  = 1'b0;
        end
      end
      LCDCS_H_START: begin
        if (tick && ph_reg == 2'h1) begin
          sda_oe_next = 1'b1;
        end
        if (last) begin
          st_next = LCDCS_H_BIT;
          sh_next = {`LCDCS_ADDR_BASE, tgt_reg, 1'b0};
          n_next  = 4'h0;
          b1_next = 1'b0;
        end
      end
      LCDCS_H_BIT, LCDCS_H_ACK: begin
        if (tick && ph_reg == 2'h0) begin
          scl_oe_next = 1'b1;
        end
        if (tick && ph_reg == 2'h1) begin
          sda_oe_next = (st_reg == LCDCS_H_BIT) ? ~sh_reg[7] : 1'b0;
        end
        if (tick && ph_reg == 2'h2) begin
          scl_oe_next = 1'b0;
        end
        if (last && st_reg == LCDCS_H_BIT) begin
          sh_next = {sh_reg[6:0], 1'b0};
          n_next  = n_reg + 4'h1;
          if (n_reg == 4'h7) begin
            st_next = LCDCS_H_ACK;
          end
        end else if (last) begin
          if (!sda_s && !b1_reg) begin
            st_next = LCDCS_H_BIT;
            sh_next = {5'h00, sub_reg};
            n_next  = 4'h0;
            b1_next = 1'b1;
          end else begin
            st_next     = LCDCS_H_STOP;
            ack_ok_next = ~sda_s;
            nack_next   = sda_s & ~(first_reg & ~b1_reg);
            // First access after power-up gets one resend when its address byte is not acknowledged
            // The flag stays up through the resent attempt until the next GO
            retry_next  = retry_reg | (sda_s & first_reg & ~b1_reg);
          end
        end
      end
      LCDCS_H_STOP: begin
        if (tick && ph_reg == 2'h0) begin
          scl_oe_next = 1'b1;
        end
        if (tick && ph_reg == 2'h1) begin
          sda_oe_next = 1'b1;
        end
        if (tick && ph_reg == 2'h2) begin
          scl_oe_next = 1'b0;
        end
        if (last) begin
          sda_oe_next = 1'b0;
          first_next  = 1'b0;
          st_next     = retry_reg && first_reg ? LCDCS_H_START : LCDCS_H_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers; wake pulses start right after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg     <= LCDCS_H_WAKE;
      q_reg      <= 8'h00;
      ph_reg     <= 2'h0;
      n_reg      <= 4'h0;
      sh_reg     <= 8'h00;
      b1_reg     <= 1'b0;
      first_reg  <= 1'b1;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      nack_reg   <= 1'b0;
      retry_reg  <= 1'b0;
      woken_reg  <= 1'b0;
    end else begin
      st_reg     <= st_next;
      q_reg      <= q_next;
      ph_reg     <= ph_next;
      n_reg      <= n_next;
      sh_reg     <= sh_next;
      b1_reg     <= b1_next;
      first_reg  <= first_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      ack_ok_reg <= ack_ok_next;
      nack_reg   <= nack_next;
      retry_reg  <= retry_next;
      woken_reg  <= woken_next;
    end
  end

  assign link.host_scl_oe = scl_oe_reg;
  assign link.host_sda_oe = sda_oe_reg;
endmodule : lcdcs_host_end

/* verilog/lcdcs_link_if.sv */
// Pins between the bus host end and one display driver end
`timescale 1ns/1ns
interface lcdcs_link_if;
  // Clock made by the host end
  logic link_clk;
  // Open-drain pins, enables high while pulling low
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic dev_sync_oe;
  logic ext_sync_oe;   // Other cascade members, driven by the bench
  // Clock pin driven by a controller-mode driver
  logic dev_clk_o;
  logic dev_clk_oe;
  // Resolved levels with pull-ups
  logic scl;
  logic sda;
  logic sync_n;

  // Wired-AND resolution of the open-drain lines
  assign scl    = ~host_scl_oe;
  assign sda    = ~(host_sda_oe | dev_sda_oe);
  assign sync_n = ~(dev_sync_oe | ext_sync_oe);

  modport host (output link_clk, output host_scl_oe, output host_sda_oe, input sda);
  modport dev  (input link_clk, input scl, input sda, input sync_n,
                output dev_sda_oe, output dev_sync_oe, output dev_clk_o, output dev_clk_oe);
endinterface : lcdcs_link_if

/* verilog/lcdcs_pkg.sv */
// Types shared by both ends of the cascade link
package lcdcs_pkg;
  typedef enum logic [2:0] {
    LCDCS_H_WAKE,
    LCDCS_H_IDLE,
    LCDCS_H_START,
    LCDCS_H_BIT,
    LCDCS_H_ACK,
    LCDCS_H_STOP
  } lcdcs_host_st_t;
endpackage : lcdcs_pkg

/* verilog/lcdcs_sync2.sv */
// Two-flop synchroniser for pin levels
`timescale 1ns/1ns
module lcdcs_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // First flop feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : lcdcs_sync2
